// [rtl/nci_pkg.sv]
// Package of the NAND command-interface host controller.
// Assumes a 20 MHz hclk; all timing counts derive from that rate.
package nci_pkg;

  // ----------------------------------------------------------------
  // Clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_WP_NS = 12;
  localparam int T_WH_NS = 10;
  localparam int T_RP_NS = 12;
  localparam int T_ADL_NS = 70;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WH_CYC = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADL_CYC = (T_ADL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PH_LOW = 4'(WP_CYC);
  localparam logic [3:0] PH_HIGH = 4'(WH_CYC + 1);
  localparam logic [3:0] PH_ADL = 4'(ADL_CYC);

  // ----------------------------------------------------------------
  // Flash command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONF = 8'hd0;
  localparam logic [7:0] CMD_READ_CB = 8'h35;
  localparam logic [7:0] CMD_CB_INPUT = 8'h85;
  localparam logic [7:0] CMD_PROG_CONF = 8'h10;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam int ID_BYTES = 5;
  localparam int ERASE_ADDR_CYC = 3;
  localparam int PLANE_BIT_POS = 20;
  localparam int STAT_READY_BIT = 6;
  localparam int STAT_FAIL_BIT = 0;
  localparam int STAT_P0_BIT = 1;
  localparam int STAT_P1_BIT = 2;

  // ----------------------------------------------------------------
  // Host register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_ID_LO = 8'h0c;
  localparam logic [7:0] REG_ID_HI = 8'h10;
  localparam int CTRL_GO_BIT = 31;
  localparam int CTRL_OP_LSB = 24;
  localparam int CTRL_ADDR_W = 24;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_RB_BIT = 9;
  localparam int ST_DONE_BIT = 10;

  // Operations that software starts through the control register.
  typedef enum logic [3:0] {
    NCI_OP_RESET = 4'h0,
    NCI_OP_STATUS = 4'h1,
    NCI_OP_READ_ID = 4'h2,
    NCI_OP_ERASE1 = 4'h3,
    NCI_OP_ERASE2 = 4'h4,
    NCI_OP_CB_READ = 4'h5,
    NCI_OP_CB_READ2 = 4'h6,
    NCI_OP_CB_PROG = 4'h7,
    NCI_OP_CB_PROG2 = 4'h8,
    NCI_OP_DATA_IN = 4'h9,
    NCI_OP_DATA_OUT = 4'ha,
    NCI_OP_REREAD = 4'hb
  } nci_op_t;

endpackage : nci_pkg

// [rtl/nci_pin_cycle.sv]
// One flash bus cycle: command, address, write data or read data.
// Assumes pins are synchronous to hclk; the flash samples on rising we.
`timescale 1ns/1ps
`default_nettype none
module nci_pin_cycle
  import nci_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Request
  input wire logic start,
  input wire logic [1:0] kind,
  input wire logic [7:0] wbyte,
  // Answer
  output logic done,
  output logic [7:0] rbyte,
  // Flash pins
  output logic cle,
  output logic ale,
  output logic write_enable_n,
  output logic read_enable_n,
  output logic [7:0] io_out,
  output logic io_oe_n,
  input wire logic [7:0] io_in
);
  typedef struct packed {
    logic busy;
    logic [3:0] cnt;
    logic low;
    logic [1:0] kind;
    logic done;
    logic [7:0] rbyte;
    logic cle;
    logic ale;
    logic wen;
    logic ren;
    logic [7:0] io;
    logic oe_n;
  } nci_cyc_t;
  nci_cyc_t q, next_q;

  // Kind 0 command, 1 address, 2 write data, 3 read data.
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (!q.busy && start) begin
      next_q.busy = 1'b1;
      next_q.low = 1'b1;
      next_q.kind = kind;
      next_q.cnt = PH_LOW;
      next_q.cle = (kind == 2'd0); // R26
      next_q.ale = (kind == 2'd1); // R26
      next_q.io = wbyte;
      next_q.oe_n = (kind == 2'd3);
      next_q.wen = (kind == 2'd3);
      next_q.ren = (kind != 2'd3);
    end else if (q.busy) begin
      if (q.cnt > 4'd1) begin
        next_q.cnt = q.cnt - 4'd1;
      end else if (q.low) begin
        next_q.low = 1'b0;
        next_q.cnt = PH_HIGH;
        next_q.wen = 1'b1;
        next_q.ren = 1'b1;
        if (q.kind == 2'd3) begin
          next_q.rbyte = io_in;
        end
      end else begin
        next_q.busy = 1'b0;
        next_q.done = 1'b1;
        next_q.cle = 1'b0;
        next_q.ale = 1'b0;
        next_q.oe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{busy: 1'b0, cnt: 4'h0, low: 1'b0, kind: 2'h0, done: 1'b0,
             rbyte: 8'h00, cle: 1'b0, ale: 1'b0, wen: 1'b1, ren: 1'b1,
             io: 8'h00, oe_n: 1'b1};
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign done = q.done;
  assign rbyte = q.rbyte;
  assign cle = q.cle;
  assign ale = q.ale;
  assign write_enable_n = q.wen;
  assign read_enable_n = q.ren;
  assign io_out = q.io;
  assign io_oe_n = q.oe_n;
endmodule : nci_pin_cycle
`default_nettype wire

// [rtl/nci_host.sv]
// Host controller for a two-plane NAND flash command interface.
// Assumes one flash on the pins and AHB-Lite single word transfers.
// Operation
// [R1] Two-plane erase: setup, three address bytes, twice, then confirm.
// [R2] Second erase setup follows first address bytes without waiting busy.
// [R3] Two-plane erase progress watched through ready_busy_n or status reads.
// [R4] First two-plane address has plane bit low, second has it high.
// [R5] Read-for-copy-back code with source address loads whole page.
// [R6] Copy-back program: data-input code, destination, then program confirm.
// [R7] During copy-back program status read shows ready and pass bits.
// [R8] After copy-back program the device stays in status mode.
// [R9] Random data input code with new column allowed during copy-back.
// [R10] Single-plane copy-back only between pages of one plane.
// [R11] Two-plane read-for-copy-back loads each plane's page buffer; NCI_OP_CB_READ2 sends one address only, plane bit high.
// [R12] Per-plane data out and data in may alternate any number of times.
// [R13] After status code each read cycle returns the status byte.
// [R14] Status output follows internal status without toggling strobes.
// [R15] After status read mid random read, reissue the read code.
// [R16] Identification code plus zero address returns five bytes.
// [R17] Identification mode stays until another command is written.
// [R18] Reset code aborts random read, program or erase in progress.
// [R19] Reset clears command register and sets status to its reset value.
// [R20] Reset during an ongoing reset is ignored.
// [R21] After reset code ready_busy_n stays low for reset busy time.
// [R22] ready_busy_n idles high, low while busy, open drain.
// [R23] chip_enable_n may rise between data cycles without harm.
// [R24] During program or erase only status and reset are accepted; the host issues only reset while it waits on busy.
// [R25] Two-plane status: bit 0 overall, bit 1 plane 0, bit 2 plane 1.
// [R26] Command latched with cle, address with ale, on rising write enable.
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module nci_host
  import nci_pkg::*;
(
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Flash pins
  output logic chip_enable_n,
  output logic command_latch_enable,
  output logic address_latch_enable,
  output logic write_enable_n,
  output logic read_enable_n,
  output logic write_protect_n,
  output logic [7:0] io_out,
  output logic io_oe_n,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_out_n
);
  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    NCI_IDLE = 3'b000,
    NCI_ISSUE = 3'b001,
    NCI_WAIT = 3'b011,
    NCI_RBWAIT = 3'b010
  } nci_state_t;

  typedef struct packed {
    nci_state_t st;
    logic [3:0] step;
    logic [3:0] op;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] status;
    logic [39:0] id;
    logic done;
    logic cen;
    logic req;
    logic [1:0] kind;
    logic [7:0] byte_out;
    logic pend_wr;
    logic [7:0] pend_addr;
    logic [31:0] hrdata;
    logic wait_rb;
  } nci_host_t;
  nci_host_t q, next_q;

  logic cyc_done;
  logic [7:0] cyc_rbyte;

  nci_pin_cycle u_cycle (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(clk_en),
    .start(q.req),
    .kind(q.kind),
    .wbyte(q.byte_out),
    .done(cyc_done),
    .rbyte(cyc_rbyte),
    .cle(command_latch_enable),
    .ale(address_latch_enable),
    .write_enable_n(write_enable_n),
    .read_enable_n(read_enable_n),
    .io_out(io_out),
    .io_oe_n(io_oe_n),
    .io_in(io_in)
  );

  // Script of one operation: returns {last, wait_rb, kind, byte} for a step.
  // Address bytes of erase are the row address, LSB first; bit 20 of the
  // full address is bit 4 of row byte 0 once the two column bytes drop.
  function automatic logic [11:0] nci_script(input logic [3:0] op,
                                             input logic [3:0] step,
                                             input logic [23:0] a,
                                             input logic [7:0] wd);
    logic [7:0] r0;
    logic [7:0] r0b;
    r0 = a[7:0];
    r0b = a[7:0];
    nci_script = 12'h000;
    r0[PLANE_BIT_POS - 16] = 1'b0; // R4
    r0b[PLANE_BIT_POS - 16] = 1'b1; // R4
    case (op)
      NCI_OP_RESET: nci_script = {2'b11, 2'd0, CMD_RESET}; // R18 R21
      NCI_OP_STATUS: begin
        case (step)
          4'd0: nci_script = {2'b00, 2'd0, CMD_STATUS}; // R13
          default: nci_script = {2'b10, 2'd3, 8'h00}; // R13
        endcase
      end
      NCI_OP_READ_ID: begin
        case (step)
          4'd0: nci_script = {2'b00, 2'd0, CMD_READ_ID}; // R16
          4'd1: nci_script = {2'b00, 2'd1, 8'h00};
          4'(ID_BYTES + 1): nci_script = {2'b10, 2'd3, 8'h00};
          default: nci_script = {2'b00, 2'd3, 8'h00};
        endcase
      end
      NCI_OP_ERASE1, NCI_OP_ERASE2: begin
        // Both setups go out back to back with no busy wait between. R2
        case (step)
          4'd0: nci_script = {2'b00, 2'd0, CMD_ERASE_SETUP}; // R1
          4'd1: nci_script = {2'b00, 2'd1,
                              op == NCI_OP_ERASE2 ? r0 : a[7:0]};
          4'd2: nci_script = {2'b00, 2'd1, a[15:8]};
          4'd3: nci_script = {2'b00, 2'd1, a[23:16]};
          4'd4: nci_script = op == NCI_OP_ERASE2 ?
                  {2'b00, 2'd0, CMD_ERASE_SETUP} :
                  {2'b11, 2'd0, CMD_ERASE_CONF};
          4'd5: nci_script = {2'b00, 2'd1, r0b};
          4'd6: nci_script = {2'b00, 2'd1, a[15:8]};
          4'd7: nci_script = {2'b00, 2'd1, a[23:16]};
          default: nci_script = {2'b11, 2'd0, CMD_ERASE_CONF}; // R1 R3
        endcase
      end
      NCI_OP_CB_READ, NCI_OP_CB_READ2, NCI_OP_CB_PROG, NCI_OP_CB_PROG2,
      NCI_OP_REREAD: begin
        case (step)
          4'd0: nci_script = {2'b00, 2'd0,
                  (op == NCI_OP_CB_PROG || op == NCI_OP_CB_PROG2) ?
                  CMD_CB_INPUT : CMD_READ}; // R6 R15
          4'd1, 4'd2: nci_script = {2'b00, 2'd1, 8'h00};
          4'd3: nci_script = {2'b00, 2'd1,
                  op == NCI_OP_CB_READ2 || op == NCI_OP_CB_PROG2 ? r0b : r0};
          4'd4: nci_script = {2'b00, 2'd1, a[15:8]};
          4'd5: nci_script = {op == NCI_OP_REREAD, 1'b0, 2'd1, a[23:16]};
          default: nci_script = (op == NCI_OP_CB_PROG ||
                                 op == NCI_OP_CB_PROG2) ?
                  {2'b11, 2'd0, CMD_PROG_CONF} :
                  {2'b11, 2'd0, CMD_READ_CB}; // R5 R6 R11
        endcase
      end
      NCI_OP_DATA_IN: begin
        // Random data input modifies copied bytes before programming. R9 R12
        case (step)
          4'd0: nci_script = {2'b00, 2'd0, CMD_CB_INPUT};
          4'd1: nci_script = {2'b00, 2'd1, a[7:0]};
          4'd2: nci_script = {2'b00, 2'd1, a[15:8]};
          default: nci_script = {2'b10, 2'd2, wd};
        endcase
      end
      default: nci_script = {2'b10, 2'd3, 8'h00}; // R12 R23
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus slave and sequencer
  // ----------------------------------------------------------------
  logic [11:0] scr;
  logic bus_go;
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    next_q.req = 1'b0;
    bus_go = hsel && hready && htrans[1] && hsize == 3'h2;
    scr = nci_script(q.op, q.step, q.addr, q.wdata);
    if (q.pend_wr && q.pend_addr == REG_CTRL && hwdata[CTRL_GO_BIT] &&
        (q.st == NCI_IDLE || (q.st == NCI_RBWAIT &&
        hwdata[CTRL_OP_LSB +: 4] == NCI_OP_RESET))) begin
      // A reset may be issued over a busy flash; others wait for idle.
      // Only the busy wait takes it, so no pin cycle is cut short. R24
      next_q.op = hwdata[CTRL_OP_LSB +: 4];
      next_q.addr = hwdata[CTRL_ADDR_W - 1:0];
      next_q.step = 4'd0;
      next_q.st = NCI_ISSUE;
      next_q.cen = 1'b0;
    end else if (q.pend_wr && q.pend_addr == REG_DATA) begin
      next_q.wdata = hwdata[7:0];
    end
    next_q.pend_wr = bus_go && hwrite;
    next_q.pend_addr = haddr;
    if (bus_go && !hwrite) begin
      case (haddr)
        REG_STATUS: next_q.hrdata = {21'h0, q.done, ~ready_busy_out_n,
                                     q.st != NCI_IDLE, q.status}; // R22
        REG_DATA: next_q.hrdata = {24'h0, q.rdata};
        REG_ID_LO: next_q.hrdata = q.id[31:0];
        REG_ID_HI: next_q.hrdata = {24'h0, q.id[39:32]};
        REG_CTRL: next_q.hrdata = {4'h0, q.op, q.addr};
        default: next_q.hrdata = 32'h0;
      endcase
    end
    case (q.st)
      NCI_ISSUE: begin
        next_q.req = 1'b1;
        next_q.kind = scr[9:8];
        next_q.byte_out = scr[7:0];
        next_q.wait_rb = scr[10];
        next_q.st = NCI_WAIT;
      end
      NCI_WAIT: begin
        if (cyc_done) begin
          if (q.kind == 2'd3) begin
            next_q.rdata = cyc_rbyte;
            // Status byte is re-read each poll, after the status code is written again.
            if (q.op == NCI_OP_STATUS) begin
              next_q.status = cyc_rbyte; // R7 R14 R25
            end
            if (q.op == NCI_OP_READ_ID) begin
              next_q.id = {cyc_rbyte, q.id[39:8]}; // R16 R17
            end
          end
          next_q.step = q.step + 4'd1;
          if (scr[11]) begin
            next_q.st = q.wait_rb ? NCI_RBWAIT : NCI_IDLE;
            next_q.done = !q.wait_rb;
          end else begin
            next_q.st = NCI_ISSUE;
          end
        end
      end
      NCI_RBWAIT: begin
        // The flash may not pull busy at once; wait for low then high.
        if (!ready_busy_out_n) begin
          next_q.wait_rb = 1'b0;
        end else if (!q.wait_rb && next_q.st == NCI_RBWAIT) begin
          next_q.st = NCI_IDLE; // R3 R21 R22
          next_q.done = 1'b1;
        end
      end
      NCI_IDLE: next_q.cen = (next_q.st == NCI_IDLE); // R23
      default: next_q.st = NCI_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.cen <= 1'b1;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  // The sequencer leaves busy-wait for idle only once ready has returned high.
  a_rbwait_hold: assert property ( // R21
    @(posedge hclk) disable iff (!hresetn)
    q.st == NCI_RBWAIT && !ready_busy_out_n && clk_en |=> q.st != NCI_IDLE)
    else $error("busy wait left while flash busy");
  a_issue_one: assert property ( // R26
    @(posedge hclk) disable iff (!hresetn)
    q.st == NCI_ISSUE && clk_en |=> q.st == NCI_WAIT && q.req)
    else $error("issue step did not request a cycle");
  a_ce_idle: assert property ( // R23
    @(posedge hclk) disable iff (!hresetn)
    q.st == NCI_IDLE && $past(q.st) == NCI_IDLE && $past(clk_en)
    |-> chip_enable_n)
    else $error("chip enable low while idle");
  a_latch_excl: assert property ( // R26
    @(posedge hclk) disable iff (!hresetn)
    !(command_latch_enable && address_latch_enable))
    else $error("command and address latch both high");
  a_strobe_ce: assert property ( // R23
    @(posedge hclk) disable iff (!hresetn)
    !write_enable_n || !read_enable_n |-> !chip_enable_n)
    else $error("strobe low while chip enable high");
  a_reset_take: assert property ( // R18
    @(posedge hclk) disable iff (!hresetn)
    q.st == NCI_RBWAIT && q.pend_wr && q.pend_addr == REG_CTRL &&
    hwdata[CTRL_GO_BIT] && hwdata[CTRL_OP_LSB +: 4] == NCI_OP_RESET &&
    clk_en |=> q.st == NCI_ISSUE && q.op == NCI_OP_RESET)
    else $error("reset refused during busy wait");

  assign chip_enable_n = q.cen;
  assign write_protect_n = 1'b1; // R19
  assign hrdata = q.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule : nci_host
`default_nettype wire

// [bench/nci_flash_model.sv]
// Behavioural NAND flash on the far side of the host controller.
// Assumes host pins change on hclk; busy times are short counts.
`timescale 1ns/1ps
`default_nettype none
module nci_flash_model
  import nci_pkg::*;
#(
  parameter logic [39:0] ID_VALUE = 40'h0, // Arbitrary identity bytes.
  parameter int RST_CYC = 40,
  parameter int OP_CYC = 120
)(
  // Clock
  input wire logic hclk,
  // Host pins
  input wire logic chip_enable_n,
  input wire logic command_latch_enable,
  input wire logic address_latch_enable,
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  input wire logic write_protect_n,
  input wire logic [7:0] io_out,
  // Fault control
  input wire logic fail_p1,
  // Device outputs
  output logic [7:0] dq_out,
  output logic rb_low
);
  // ----------------------------------------------------------------
  // Command decoder
  // ----------------------------------------------------------------
  int cnt = 0;
  logic [1:0] kind = 2'h0; // Idle, reset, program or erase, read.
  logic [1:0] mode = 2'h0; // Data, status, identification.
  logic [7:0] st = 8'he0;
  logic [7:0] last_cmd = 8'h00;
  logic [7:0] last_dq = 8'h00;
  logic [7:0] data_byte = 8'h00;
  logic [7:0] id_addr = 8'hff;
  logic [7:0] val;
  logic [1:0] plane = 2'h0;
  logic we_d = 1'b1;
  logic re_d = 1'b1;
  logic drv;
  int setups = 0, acnt = 0, id_idx = 0, erase_setups = 0, erase_acnt = 0;
  int reset_cnt = 0, abort_cnt = 0, cb_cnt = 0, prog_cnt = 0;
  assign rb_low = (cnt != 0);
  assign drv = !chip_enable_n && !read_enable_n;
  // A released bus shows the inverse of its last byte, never a copy.
  assign val = (mode == 2'h1) ? {st[7], ~rb_low, st[5:0]} :
    (mode == 2'h2) ? ID_VALUE[8 * (id_idx % ID_BYTES) +: 8] : 8'h00;
  assign dq_out = drv ? val : ~last_dq;
  always @(posedge hclk) begin
    we_d <= write_enable_n;
    re_d <= read_enable_n;
    if (drv) last_dq <= val;
    if (read_enable_n && !re_d && mode == 2'h2) id_idx <= id_idx + 1;
    if (cnt > 1) cnt <= cnt - 1;
    else if (cnt == 1) begin
      cnt <= 0;
      kind <= 2'h0;
    end
    if (write_enable_n && !we_d && !chip_enable_n) begin
      if (command_latch_enable) begin
        last_cmd <= io_out;
        if (io_out == CMD_RESET) begin
          if (kind != 2'h1) begin
            reset_cnt <= reset_cnt + 1;
            if (kind != 2'h0) abort_cnt <= abort_cnt + 1;
            kind <= 2'h1;
            cnt <= RST_CYC;
            mode <= 2'h0;
            setups <= 0;
            if (write_protect_n) st <= 8'he0;
          end
        end else if (io_out == CMD_STATUS) mode <= 2'h1;
        else if (kind == 2'h0 || kind == 2'h3) begin
          mode <= 2'h0;
          acnt <= 0;
          case (io_out)
            CMD_ERASE_SETUP: setups <= setups + 1;
            CMD_ERASE_CONF: begin
              erase_setups <= setups;
              erase_acnt <= acnt;
              setups <= 0;
              kind <= 2'h2;
              cnt <= OP_CYC;
              st <= 8'he0 | (8'(fail_p1) << STAT_FAIL_BIT) |
                (8'(fail_p1) << STAT_P1_BIT);
            end
            CMD_READ_CB: begin
              cb_cnt <= cb_cnt + 1;
              kind <= 2'h3;
              cnt <= OP_CYC;
            end
            CMD_PROG_CONF: begin
              prog_cnt <= prog_cnt + 1;
              kind <= 2'h2;
              cnt <= OP_CYC;
              mode <= 2'h1;
              st <= 8'he0;
            end
            CMD_READ_ID: begin
              mode <= 2'h2;
              id_idx <= 0;
            end
            default: ;
          endcase
        end
      end else if (address_latch_enable) begin
        acnt <= acnt + 1;
        if (last_cmd == CMD_ERASE_SETUP && acnt == 0 && setups > 0)
          plane[setups - 1] <= io_out[PLANE_BIT_POS - 16];
        if (last_cmd == CMD_READ_ID) id_addr <= io_out;
      end else if (last_cmd == CMD_CB_INPUT) data_byte <= io_out;
    end
  end
endmodule : nci_flash_model
`default_nettype wire

// [bench/nci_host_tb.sv]
// Self-checking bench of the NAND host controller.
// Assumes the flash model of this folder; AHB-Lite master in tasks.
`timescale 1ns/1ps
`default_nettype none
module nci_host_tb;
  import nci_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam logic [39:0] ID_VALUE = 40'h3c_a5_96_c3_5a; // Arbitrary.
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic fail_p1 = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, ce_n, cle, ale, we_n, re_n, wp_n, oe_n, rb_low;
  logic [7:0] io_out, dq;
  logic ready_busy_out_n;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  assign ready_busy_out_n = rb_low ? 1'b0 : 1'b1; // Pull-up on the wire.
  always #25 hclk = ~hclk;
  nci_host nci_host_i (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chip_enable_n(ce_n),
    .command_latch_enable(cle), .address_latch_enable(ale),
    .write_enable_n(we_n), .read_enable_n(re_n), .write_protect_n(wp_n),
    .io_out(io_out), .io_oe_n(oe_n), .io_in(dq),
    .ready_busy_out_n(ready_busy_out_n));
  nci_flash_model #(.ID_VALUE(ID_VALUE), .RST_CYC(40), .OP_CYC(120))
    nci_flash_model_i (.hclk(hclk), .chip_enable_n(ce_n),
    .command_latch_enable(cle), .address_latch_enable(ale),
    .write_enable_n(we_n), .read_enable_n(re_n), .write_protect_n(wp_n),
    .io_out(io_out), .fail_p1(fail_p1), .dq_out(dq), .rb_low(rb_low));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask : rd
  task automatic op(input nci_op_t o, input logic [23:0] a);
    logic [31:0] d;
    xfer(1'b1, REG_CTRL, {1'b1, 3'h0, o, a}, d);
  endtask : op
  // The global cycle ceiling bounds both polling loops.
  task automatic wait_idle();
    logic [31:0] s;
    do rd(REG_STATUS, s); while (s[ST_BUSY_BIT] !== 1'b0);
  endtask : wait_idle
  task automatic wait_rb_low();
    logic [31:0] s;
    do rd(REG_STATUS, s); while (s[ST_RB_BIT] !== 1'b1);
  endtask : wait_rb_low
  task automatic status_is(input logic [7:0] exp);
    logic [31:0] s;
    op(NCI_OP_STATUS, 24'h0);
    wait_idle();
    rd(REG_STATUS, s);
    check(32'(s[7:0]), 32'(exp));
    check(32'(s[ST_RB_BIT]), 32'h0);
  endtask : status_is
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    int r0;
    logic [31:0] s;
    r0 = nci_flash_model_i.reset_cnt;
    op(NCI_OP_RESET, 24'h0);
    wait_rb_low();
    op(NCI_OP_RESET, 24'h0);
    wait_idle();
    check(32'(nci_flash_model_i.reset_cnt - r0), 32'h1);
    status_is(8'he0);
    rd(8'h14, s);
    check(s, 32'h0);
  endtask : t_reset
  task automatic t_read_id();
    logic [31:0] s;
    op(NCI_OP_READ_ID, 24'h0);
    wait_idle();
    check(32'(nci_flash_model_i.id_addr), 32'h0);
    rd(REG_ID_LO, s);
    check(s, ID_VALUE[31:0]);
    rd(REG_ID_HI, s);
    check(s, 32'(ID_VALUE[39:32]));
    op(NCI_OP_DATA_OUT, 24'h0);
    wait_idle();
    rd(REG_DATA, s);
    check(32'(s[7:0]), 32'(ID_VALUE[7:0]));
  endtask : t_read_id
  task automatic t_erase2();
    logic [31:0] s;
    fail_p1 <= 1'b1;
    op(NCI_OP_ERASE2, 24'h000100);
    rd(REG_CTRL, s);
    check(s, {4'h0, NCI_OP_ERASE2, 24'h000100});
    wait_rb_low();
    wait_idle();
    check(32'(nci_flash_model_i.erase_setups), 32'h2);
    check(32'(nci_flash_model_i.erase_acnt), ERASE_ADDR_CYC);
    check(32'(nci_flash_model_i.plane), 32'h2);
    status_is(8'he0 | (8'h1 << STAT_FAIL_BIT) | (8'h1 << STAT_P1_BIT));
    fail_p1 <= 1'b0;
  endtask : t_erase2
  task automatic t_abort();
    int a0;
    a0 = nci_flash_model_i.abort_cnt;
    op(NCI_OP_ERASE1, 24'h0);
    wait_rb_low();
    op(NCI_OP_RESET, 24'h0);
    wait_idle();
    check(32'(nci_flash_model_i.abort_cnt - a0), 32'h1);
    status_is(8'he0);
  endtask : t_abort
  task automatic t_copyback();
    int c0;
    int p0;
    logic [31:0] s;
    for (int i = 0; i < 2; i++) begin
      c0 = nci_flash_model_i.cb_cnt;
      p0 = nci_flash_model_i.prog_cnt;
      op(i ? NCI_OP_CB_READ2 : NCI_OP_CB_READ, 24'h000200);
      wait_idle();
      check(32'(nci_flash_model_i.cb_cnt - c0), 32'h1);
      xfer(1'b1, REG_DATA, 32'h3c + 32'(i), s);
      op(NCI_OP_DATA_IN, 24'h000010);
      wait_idle();
      check(32'(nci_flash_model_i.data_byte), 32'h3c + 32'(i));
      op(i ? NCI_OP_CB_PROG2 : NCI_OP_CB_PROG, 24'h000400);
      wait_idle();
      check(32'(nci_flash_model_i.prog_cnt - p0), 32'h1);
      op(NCI_OP_DATA_OUT, 24'h0);
      wait_idle();
      rd(REG_DATA, s);
      check(32'(s[7:0]), 32'he0);
    end
    op(NCI_OP_REREAD, 24'h000200);
    wait_idle();
    check(32'(nci_flash_model_i.last_cmd), 32'(CMD_READ));
    check(32'(nci_flash_model_i.mode), 32'h0);
  endtask : t_copyback
  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge hclk);
    check({24'h0, ce_n, we_n, re_n, oe_n, cle, ale, wp_n, hresp},
          32'hf2);
    check(hrdata, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_read_id();
    t_erase2();
    t_abort();
    t_copyback();
    stop_test();
  end
endmodule : nci_host_tb
`default_nettype wire
